// ### debug_mode_controller.sv
// Debug mode controller: entry, exit, trigger, trap entry and run state
`timescale 1ns/100ps
module debug_mode_controller (
   input  wire logic                     clk_i,
   input  wire logic                     rst_i,
   input  wire logic                     fetch_permit_i,
   input  wire logic                     debug_entry_request_i,
   input  wire logic [31:0]              halt_vector_in_i,
   input  wire logic [31:0]              debug_trap_vector_in_i,
   input  wire logic [31:0]              irq_lines_i,
   input  wire debug_ctrl_pkg::decode_t  decode_i,
   output logic                          squash_o,
   output debug_ctrl_pkg::redirect_t     redirect_o,
   output logic [31:0]                   csr_rdata_o,
   output logic                          debug_mode_o,
   output logic                          reset_seen_status_o,
   output logic                          run_status_out_o,
   output logic                          halt_status_out_o,
   input  wire logic                     wb_cyc_i,
   input  wire logic                     wb_stb_i,
   input  wire logic                     wb_we_i,
   input  wire logic [7:0]               wb_adr_i,
   input  wire logic [3:0]               wb_sel_i,
   input  wire logic [31:0]              wb_dat_i,
   output logic [31:0]                   wb_dat_o,
   output logic                          wb_ack_o
);
   import debug_ctrl_pkg::*;

   // Architectural state
   run_state_t  state;
   logic        dmode;
   logic [31:0] saved_pc;
   logic [2:0]  dcause;
   logic        break_en;
   logic [31:0] scratch0;
   logic [31:0] scratch1;
   logic        trig_exec;
   logic [31:0] trig_addr;
   logic        gie;
   logic        prev_gie;
   logic [31:0] irq_mask;
   logic [31:0] trap_base;
   logic [31:0] trap_pc;
   logic [31:0] trap_cause;
   logic        req_seen;

   // Next values
   run_state_t  next_state;
   logic        next_dmode;
   logic [31:0] next_saved_pc;
   logic [2:0]  next_dcause;
   logic        next_break_en;
   logic [31:0] next_scratch0;
   logic [31:0] next_scratch1;
   logic        next_trig_exec;
   logic [31:0] next_trig_addr;
   logic        next_gie;
   logic        next_prev_gie;
   logic [31:0] next_irq_mask;
   logic [31:0] next_trap_base;
   logic [31:0] next_trap_pc;
   logic [31:0] next_trap_cause;
   logic        next_squash;
   redirect_t   next_redirect;
   logic [31:0] next_rdata;

   // Synchronisers for pin inputs
   logic        permit_meta;
   logic        permit_ok;
   logic [31:0] irq_meta;
   logic [31:0] irq_sync;

   logic        wb_hit;
   logic        wb_wr;
   logic        trig_hit;
   logic        irq_hit;
   logic        dbg_reg;
   logic [31:0] ctrl_word;
   logic [31:0] trig_one_word;
   logic [31:0] wmask;

   // Pins come from outside the clock domain
   always_ff @(posedge clk_i) begin
      permit_meta <= fetch_permit_i;
      permit_ok   <= permit_meta;
      irq_meta    <= irq_lines_i;
      irq_sync    <= irq_meta;
   end

   // Byte-lane write mask from Wishbone select
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_lane
         assign wmask[8*g+7:8*g] = {8{wb_sel_i[g]}};
      end
   endgenerate

   assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   // Write lands at the edge where the master sees ack, while it still holds the request
   assign wb_wr  = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i;

   // Readable images of the debug control word and trigger word
   always_comb begin
      ctrl_word = RESET_WORD;
      ctrl_word[DBG_BREAK_EN_BIT] = break_en;
      ctrl_word[DBG_CAUSE_LSB +: 3] = dcause;
      trig_one_word = RESET_WORD;
      trig_one_word[TRIG_TYPE_LSB +: 4] = TRIG_TYPE_MATCH;
      trig_one_word[TRIG_DMODE_BIT] = 1'b1;
      trig_one_word[TRIG_EXEC_BIT] = trig_exec;
   end

   // Trigger matches the fetched address; interrupts masked in debug mode
   assign trig_hit = trig_exec & decode_i.valid & (decode_i.pc == trig_addr);
   assign irq_hit  = gie & ~dmode & (|(irq_sync & irq_mask));
   assign dbg_reg  = (decode_i.sel == SEL_DBG_CTRL) | (decode_i.sel == SEL_DBG_PC) |
                     (decode_i.sel == SEL_SCRATCH0) | (decode_i.sel == SEL_SCRATCH1);

   // Register read mux for instruction-side accesses
   always_comb begin
      unique case (decode_i.sel)
         SEL_DBG_CTRL:  next_rdata = ctrl_word;
         SEL_DBG_PC:    next_rdata = saved_pc;
         SEL_SCRATCH0:  next_rdata = scratch0;
         SEL_SCRATCH1:  next_rdata = scratch1;
         SEL_TRIG_SEL:  next_rdata = RESET_WORD;
         SEL_TRIG_ONE:  next_rdata = trig_one_word;
         SEL_TRIG_TWO:  next_rdata = trig_addr;
         SEL_TRIG_INFO: next_rdata = TRIG_INFO_VAL;
      endcase
      if (!dmode && dbg_reg) begin
         next_rdata = RESET_WORD;
      end
   end

   // Sequencing: bus writes first, then hardware events override them
   always_comb begin
      next_state      = state;
      next_dmode      = dmode;
      next_saved_pc   = saved_pc;
      next_dcause     = dcause;
      next_break_en   = break_en;
      next_scratch0   = scratch0;
      next_scratch1   = scratch1;
      next_trig_exec  = trig_exec;
      next_trig_addr  = trig_addr;
      next_gie        = gie;
      next_prev_gie   = prev_gie;
      next_irq_mask   = irq_mask;
      next_trap_base  = trap_base;
      next_trap_pc    = trap_pc;
      next_trap_cause = trap_cause;
      next_squash     = 1'b0;
      next_redirect   = '0;
      // Software writes over the bus
      if (wb_wr) begin
         unique case (wb_adr_i)
            ADR_IRQ_CTRL: begin
               if (wb_sel_i[0]) begin
                  next_gie      = wb_dat_i[IRQ_CTRL_GIE];
                  next_prev_gie = wb_dat_i[IRQ_CTRL_PREV];
               end
            end
            ADR_IRQ_MASK:   next_irq_mask   = (irq_mask & ~wmask) | (wb_dat_i & wmask);
            ADR_TRAP_BASE:  next_trap_base  = (trap_base & ~wmask) | (wb_dat_i & wmask);
            ADR_TRAP_PC:    next_trap_pc    = (trap_pc & ~wmask) | (wb_dat_i & wmask);
            default: ;
         endcase
      end
      if (state == ST_RESET) begin
         // Leave the reset phase once fetch permit is seen high
         if (permit_ok) begin
            if (debug_entry_request_i || req_seen) begin
               next_dmode        = 1'b1;
               next_saved_pc     = decode_i.pc;
               next_dcause       = DCAUSE_HALTREQ;
               next_redirect     = '{valid: 1'b1, target: halt_vector_in_i};
               next_squash       = 1'b1;
            end
            next_state = (debug_entry_request_i || req_seen) ? ST_HALT : ST_RUN;
         end
      end else begin
         if (!dmode && (debug_entry_request_i || trig_hit)) begin
            // Synchronous request needs no synchroniser
            next_dmode    = 1'b1;
            next_saved_pc = decode_i.pc;
            next_dcause   = debug_entry_request_i ? DCAUSE_HALTREQ : DCAUSE_TRIGGER;
            next_redirect = '{valid: 1'b1, target: halt_vector_in_i};
            next_squash   = 1'b1;
         end else if (irq_hit) begin
            // Interrupt entry; no trap value is captured
            next_trap_pc    = decode_i.pc;
            next_trap_cause = {1'b1, 26'h0, 5'h00} | {27'h0, 5'h00};
            next_prev_gie   = gie;
            next_gie        = 1'b0;
            next_redirect   = '{valid: 1'b1, target: trap_base};
            next_squash     = 1'b1;
         end else if (decode_i.valid) begin
            unique case (decode_i.op)
               OP_EBREAK: begin
                  next_squash = 1'b1;
                  if (dmode) begin
                     next_redirect = '{valid: 1'b1, target: halt_vector_in_i};
                  end else if (break_en) begin
                     next_dmode    = 1'b1;
                     next_saved_pc = decode_i.pc;
                     next_dcause   = DCAUSE_EBREAK;
                     next_redirect = '{valid: 1'b1, target: halt_vector_in_i};
                  end else begin
                     next_trap_pc    = decode_i.pc;
                     next_trap_cause = {27'h0, EXC_BREAKPOINT};
                     next_prev_gie   = gie;
                     next_gie        = 1'b0;
                     next_redirect   = '{valid: 1'b1, target: trap_base};
                  end
               end
               OP_MRET: begin
                  next_squash = 1'b1;
                  if (dmode) begin
                     next_redirect = '{valid: 1'b1, target: debug_trap_vector_in_i};
                  end else begin
                     next_gie      = prev_gie;
                     next_prev_gie = 1'b1;
                     next_redirect = '{valid: 1'b1, target: trap_pc};
                  end
               end
               OP_DRET: begin
                  next_squash = 1'b1;
                  if (dmode) begin
                     next_dmode    = 1'b0;
                     next_redirect = '{valid: 1'b1, target: saved_pc};
                  end else begin
                     next_trap_pc    = decode_i.pc;
                     next_trap_cause = {27'h0, EXC_ILLEGAL};
                     next_prev_gie   = gie;
                     next_gie        = 1'b0;
                     next_redirect   = '{valid: 1'b1, target: trap_base};
                  end
               end
               OP_FAULT: begin
                  next_squash = 1'b1;
                  if (dmode) begin
                     next_redirect = '{valid: 1'b1, target: debug_trap_vector_in_i};
                  end else begin
                     next_trap_pc    = decode_i.pc;
                     next_trap_cause = {27'h0, decode_i.cause};
                     next_prev_gie   = gie;
                     next_gie        = 1'b0;
                     next_redirect   = '{valid: 1'b1, target: trap_base};
                  end
               end
               OP_CSR: begin
                  if (!dmode && dbg_reg) begin
                     // Debug registers are private to debug mode
                     next_squash     = 1'b1;
                     next_trap_pc    = decode_i.pc;
                     next_trap_cause = {27'h0, EXC_ILLEGAL};
                     next_prev_gie   = gie;
                     next_gie        = 1'b0;
                     next_redirect   = '{valid: 1'b1, target: trap_base};
                  end else if (decode_i.we && dmode) begin
                     // Only debug-mode writes reach here; trigger writes outside debug mode are ignored
                     unique case (decode_i.sel)
                        SEL_DBG_CTRL:  next_break_en = decode_i.wdata[DBG_BREAK_EN_BIT];
                        SEL_DBG_PC:    next_saved_pc = decode_i.wdata;
                        SEL_SCRATCH0:  next_scratch0 = decode_i.wdata;
                        SEL_SCRATCH1:  next_scratch1 = decode_i.wdata;
                        SEL_TRIG_ONE:  next_trig_exec = decode_i.wdata[TRIG_EXEC_BIT];
                        SEL_TRIG_TWO:  next_trig_addr = decode_i.wdata;
                        default: ;
                     endcase
                  end
               end
               default: ;
            endcase
         end
         next_state = next_dmode ? ST_HALT : ST_RUN;
      end
   end

   // Run state and debug mode
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state    <= ST_RESET;
         dmode    <= 1'b0;
         req_seen <= 1'b0;
      end else begin
         state    <= next_state;
         dmode    <= next_dmode;
         // Remember an early request until the reset phase ends
         req_seen <= (state == ST_RESET) & (req_seen | debug_entry_request_i);
      end
   end

   // Status outputs decoded from one state code, so never overlap
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         reset_seen_status_o <= 1'b1;
         run_status_out_o    <= 1'b0;
         halt_status_out_o   <= 1'b0;
         debug_mode_o        <= 1'b0;
      end else begin
         reset_seen_status_o <= (next_state == ST_RESET);
         run_status_out_o    <= (next_state == ST_RUN);
         halt_status_out_o   <= (next_state == ST_HALT);
         debug_mode_o        <= next_dmode;
      end
   end

   // Debug and trigger registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         saved_pc  <= RESET_WORD;
         dcause    <= 3'h0;
         break_en  <= 1'b0;
         scratch0  <= RESET_WORD;
         scratch1  <= RESET_WORD;
         trig_exec <= 1'b0;
         trig_addr <= RESET_WORD;
      end else begin
         saved_pc  <= next_saved_pc;
         dcause    <= next_dcause;
         break_en  <= next_break_en;
         scratch0  <= next_scratch0;
         scratch1  <= next_scratch1;
         trig_exec <= next_trig_exec;
         trig_addr <= next_trig_addr;
      end
   end

   // Trap and interrupt control registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gie        <= 1'b0;
         prev_gie   <= 1'b0;
         irq_mask   <= RESET_WORD;
         trap_base  <= RESET_WORD;
         trap_pc    <= RESET_WORD;
         trap_cause <= RESET_WORD;
      end else begin
         gie        <= next_gie;
         prev_gie   <= next_prev_gie;
         irq_mask   <= next_irq_mask;
         trap_base  <= next_trap_base;
         trap_pc    <= next_trap_pc;
         trap_cause <= next_trap_cause;
      end
   end

   // Pipeline-facing outputs, one cycle after the decision
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         squash_o    <= 1'b0;
         redirect_o  <= '0;
         csr_rdata_o <= RESET_WORD;
      end else begin
         squash_o    <= next_squash;
         redirect_o  <= next_redirect;
         csr_rdata_o <= next_rdata;
      end
   end

   // Wishbone slave: ack one cycle after strobe; unmapped reads give zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= RESET_WORD;
      end else begin
         wb_ack_o <= wb_hit;
         if (wb_hit && !wb_we_i) begin
            unique case (wb_adr_i)
               ADR_IRQ_CTRL:   wb_dat_o <= {30'h0, prev_gie, gie};
               ADR_IRQ_MASK:   wb_dat_o <= irq_mask;
               ADR_TRAP_BASE:  wb_dat_o <= trap_base;
               ADR_TRAP_PC:    wb_dat_o <= trap_pc;
               ADR_TRAP_CAUSE: wb_dat_o <= trap_cause;
               ADR_DBG_STAT:   wb_dat_o <= ctrl_word | {31'h0, dmode};
               ADR_DBG_PC:     wb_dat_o <= saved_pc;
               default:        wb_dat_o <= RESET_WORD;
            endcase
         end else begin
            wb_dat_o <= RESET_WORD;
         end
      end
   end

endmodule

// ### debug_ctrl_pkg.sv
// Shared types, register map and encodings for the debug mode controller
package debug_ctrl_pkg;

   // Run state shown to the debug module; exactly one flag at a time
   typedef enum logic [1:0] {
      ST_RESET = 2'b00,
      ST_RUN   = 2'b01,
      ST_HALT  = 2'b10
   } run_state_t;

   // Kind of instruction sitting in decode
   typedef enum logic [2:0] {
      OP_NONE   = 3'b000,
      OP_PLAIN  = 3'b001,
      OP_EBREAK = 3'b010,
      OP_MRET   = 3'b011,
      OP_DRET   = 3'b100,
      OP_CSR    = 3'b101,
      OP_FAULT  = 3'b110
   } op_t;

   // Debug and trigger register selected by a register instruction
   typedef enum logic [2:0] {
      SEL_DBG_CTRL   = 3'b000,
      SEL_DBG_PC     = 3'b001,
      SEL_SCRATCH0   = 3'b010,
      SEL_SCRATCH1   = 3'b011,
      SEL_TRIG_SEL   = 3'b100,
      SEL_TRIG_ONE   = 3'b101,
      SEL_TRIG_TWO   = 3'b110,
      SEL_TRIG_INFO  = 3'b111
   } csr_sel_t;

   // Instruction presented by decode
   typedef struct packed {
      logic        valid;
      op_t         op;
      logic [31:0] pc;
      logic [4:0]  cause;
      csr_sel_t    sel;
      logic        we;
      logic [31:0] wdata;
   } decode_t;

   // Fetch redirect request
   typedef struct packed {
      logic        valid;
      logic [31:0] target;
   } redirect_t;

   // Wishbone byte offsets
   localparam logic [7:0] ADR_IRQ_CTRL  = 8'h00;
   localparam logic [7:0] ADR_IRQ_MASK  = 8'h04;
   localparam logic [7:0] ADR_TRAP_BASE = 8'h08;
   localparam logic [7:0] ADR_TRAP_PC   = 8'h0C;
   localparam logic [7:0] ADR_TRAP_CAUSE= 8'h10;
   localparam logic [7:0] ADR_DBG_STAT  = 8'h14;
   localparam logic [7:0] ADR_DBG_PC    = 8'h18;

   // Field positions
   localparam int IRQ_CTRL_GIE      = 0;
   localparam int IRQ_CTRL_PREV     = 1;
   localparam int DBG_BREAK_EN_BIT  = 15;
   localparam int DBG_CAUSE_LSB     = 6;
   localparam int DBG_MODE_BIT      = 0;
   localparam int TRIG_DMODE_BIT    = 27;
   localparam int TRIG_EXEC_BIT     = 2;
   localparam int TRIG_TYPE_LSB     = 28;

   // Constants
   localparam logic [3:0]  TRIG_TYPE_MATCH = 4'h2;
   localparam logic [31:0] TRIG_INFO_VAL   = 32'h0000_0004;
   localparam logic [2:0]  DCAUSE_EBREAK   = 3'h1;
   localparam logic [2:0]  DCAUSE_TRIGGER  = 3'h2;
   localparam logic [2:0]  DCAUSE_HALTREQ  = 3'h3;
   localparam logic [4:0]  EXC_ILLEGAL     = 5'h02;
   localparam logic [4:0]  EXC_BREAKPOINT  = 5'h03;
   localparam logic [31:0] RESET_WORD      = 32'h0000_0000;

endpackage

// ### dbg_checker.sv
// Assertion checker watching the debug mode controller ports
`timescale 1ns/100ps
module dbg_checker (
   input wire logic                      clk_i,
   input wire logic                      rst_i,
   input wire logic                      fetch_permit_i,
   input wire logic                      debug_entry_request_i,
   input wire logic [31:0]               halt_vector_in_i,
   input wire logic [31:0]               debug_trap_vector_in_i,
   input wire debug_ctrl_pkg::decode_t   decode_i,
   input wire logic                      squash_o,
   input wire debug_ctrl_pkg::redirect_t redirect_o,
   input wire logic                      debug_mode_o,
   input wire logic                      reset_seen_status_o,
   input wire logic                      run_status_out_o,
   input wire logic                      halt_status_out_o
);
   import debug_ctrl_pkg::*;
   logic dv;
   // Valid decode with no halt request competing for priority
   assign dv = decode_i.valid && !debug_entry_request_i;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_onehot;
      $onehot({reset_seen_status_o, run_status_out_o, halt_status_out_o});
   endproperty
   a_onehot: assert property (p_onehot) else $error("run state not one-hot");
   property p_req;
      run_status_out_o && debug_entry_request_i |=> halt_status_out_o && squash_o
         && redirect_o.valid && redirect_o.target == $past(halt_vector_in_i);
   endproperty
   a_req: assert property (p_req) else $error("request did not halt");
   property p_mode;
      !reset_seen_status_o |-> halt_status_out_o == debug_mode_o;
   endproperty
   a_mode: assert property (p_mode) else $error("halt flag differs from mode");
   property p_dbrk;
      debug_mode_o && dv && decode_i.op == OP_EBREAK |=> debug_mode_o
         && redirect_o.valid && redirect_o.target == $past(halt_vector_in_i);
   endproperty
   a_dbrk: assert property (p_dbrk) else $error("debug ebreak target wrong");
   property p_dtrap;
      debug_mode_o && dv && decode_i.op inside {OP_MRET, OP_FAULT} |=> debug_mode_o
         && redirect_o.valid && redirect_o.target == $past(debug_trap_vector_in_i);
   endproperty
   a_dtrap: assert property (p_dtrap) else $error("debug trap target wrong");
   property p_dret;
      debug_mode_o && dv && decode_i.op == OP_DRET |=> redirect_o.valid && run_status_out_o
         && !debug_mode_o;
   endproperty
   a_dret: assert property (p_dret) else $error("dret did not resume");
   property p_early;
      reset_seen_status_o && debug_entry_request_i |=> !run_status_out_o;
   endproperty
   a_early: assert property (p_early) else $error("early request passed through running");
   property p_stay;
      debug_mode_o && !(decode_i.valid && decode_i.op == OP_DRET) |=> debug_mode_o;
   endproperty
   a_stay: assert property (p_stay) else $error("debug mode left without dret");
   property p_hold;
      (!fetch_permit_i)[*4] ##0 reset_seen_status_o |=> reset_seen_status_o;
   endproperty
   a_hold: assert property (p_hold) else $error("reset flag dropped early");
endmodule
bind debug_mode_controller dbg_checker u_dbg_checker (.*);

// ### debug_module_model.sv
// Behavioural debug module raising and holding the halt request
`timescale 1ns/100ps
module debug_module_model (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic go_i,
   input  wire logic halted_i,
   output logic      req_o
);
   logic held;
   // Held until the core reports halted, never for less than a period
   always_ff @(posedge clk_i) begin
      if (rst_i)
         held <= 1'b0;
      else
         held <= req_o && !halted_i;
   end
   // Launched right after an edge, same clock as the core
   assign req_o = go_i || held;
endmodule

// ### debug_mode_controller_tb.sv
// Self-checking bench for the debug mode controller
`timescale 1ns/100ps
module debug_mode_controller_tb;
   import debug_ctrl_pkg::*;
   localparam logic [31:0] HALT  = 32'h0000_1000;
   localparam logic [31:0] DTRAP = 32'h0000_2000;
   localparam logic [31:0] TBASE = 32'h0000_3000;
   localparam logic [31:0] TADR  = 32'h0000_0400;
   logic        clk_i, rst_i, fp, go, req, cyc, stb, wwe, sq, dm, rs, rn, hs, ack, irq;
   logic [7:0]  adr;
   logic [31:0] wdat, q, s, rdat, wbq;
   decode_t     dec;
   redirect_t   rd;
   int          n, n_errors = 0, tests_run = 0;

   debug_mode_controller u_debug_mode_controller (
      .clk_i(clk_i), .rst_i(rst_i), .fetch_permit_i(fp), .debug_entry_request_i(req),
      .halt_vector_in_i(HALT), .debug_trap_vector_in_i(DTRAP), .irq_lines_i({31'h0, irq}),
      .decode_i(dec), .squash_o(sq), .redirect_o(rd), .csr_rdata_o(rdat),
      .debug_mode_o(dm), .reset_seen_status_o(rs), .run_status_out_o(rn),
      .halt_status_out_o(hs), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(wwe),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wbq), .wb_ack_o(ack));
   debug_module_model u_debug_module_model (
      .clk_i(clk_i), .rst_i(rst_i), .go_i(go), .halted_i(hs), .req_o(req));

   // 100 MHz core clock
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Classic single cycle; waits for ack, only the watchdog ends a hang; data taken at that edge
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      {cyc, stb, wwe, adr, wdat} <= {2'b11, w, a, d};
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      q = wbq;
      {cyc, stb} <= 2'b00;
      #1;
   endtask

   // One instruction in decode for one cycle, optionally with a halt request
   task automatic issue(input op_t op, input logic [31:0] pc = 32'h0,
                        input csr_sel_t sl = SEL_DBG_CTRL, input logic w = 1'b0,
                        input logic [31:0] d = 32'h0, input logic r = 1'b0);
      @(posedge clk_i);
      dec <= '{1'b1, op, pc, 5'h00, sl, w, d};
      go <= r;
      @(posedge clk_i);
      dec <= '0;
      go <= 1'b0;
      #1;
   endtask

   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Hang guard; the sequence needs well under a thousand cycles
   initial begin
      #20000;
      n_errors++;
      finish_test;
   end

   // Main sequence
   initial begin
      {rst_i, fp, go, cyc, stb, wwe, irq} = 7'h40;
      adr = 8'h00;
      wdat = 32'h0;
      dec = '0;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      go <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
      fp <= 1'b1;
      n = 0;
      while (rs !== 1'b0 && n < 20) begin
         @(posedge clk_i);
         n++;
      end
      #1;
      chk("early_halt", {rn, hs}, 2'b01);
      wb(1'b0, ADR_DBG_STAT, 32'h0);
      chk("brk_en_reset", q[DBG_BREAK_EN_BIT], 1'b0);
      chk("halt_cause", q[DBG_CAUSE_LSB +: 3], DCAUSE_HALTREQ);
      $display("test early_halt done");
      issue(OP_CSR, 32'h0, SEL_DBG_CTRL, 1'b1, 32'h0000_8000);
      wb(1'b0, ADR_DBG_STAT, 32'h0);
      s = q;
      chk("brk_en_set", s[DBG_BREAK_EN_BIT], 1'b1);
      issue(OP_EBREAK);
      chk("dbg_ebreak", {dm, rd.target}, {1'b1, HALT});
      wb(1'b0, ADR_DBG_STAT, 32'h0);
      chk("dbg_ebreak_stat", q, s);
      for (int i = 0; i < 2; i++) begin
         issue(i ? OP_FAULT : OP_MRET);
         chk("dbg_trap_vec", {dm, rd.target}, {1'b1, DTRAP});
      end
      issue(OP_CSR, 32'h0, SEL_TRIG_ONE, 1'b1, 32'h2000_0004);
      issue(OP_CSR, 32'h0, SEL_TRIG_TWO, 1'b1, TADR);
      issue(OP_CSR, 32'h0, SEL_TRIG_ONE);
      chk("trig_dmode", rdat[TRIG_DMODE_BIT], 1'b1);
      issue(OP_DRET);
      $display("test debug_ops done");
      issue(OP_EBREAK, 32'h0000_0100);
      chk("ebreak_enter", {dm, rd.target}, {1'b1, HALT});
      wb(1'b0, ADR_DBG_STAT, 32'h0);
      chk("ebreak_cause", q[DBG_CAUSE_LSB +: 3], DCAUSE_EBREAK);
      wb(1'b0, ADR_DBG_PC, 32'h0);
      chk("ebreak_pc", q, 32'h0000_0100);
      issue(OP_DRET);
      chk("dret_target", rd.target, 32'h0000_0100);
      issue(OP_CSR, 32'h0, SEL_TRIG_TWO, 1'b1, 32'h0000_0800);
      issue(OP_CSR, 32'h0, SEL_TRIG_TWO);
      chk("trig_locked", rdat, TADR);
      issue(OP_PLAIN, TADR);
      wb(1'b0, ADR_DBG_STAT, 32'h0);
      chk("trig_entry", {dm, 29'h0, q[DBG_CAUSE_LSB +: 3]}, {1'b1, 29'h0, DCAUSE_TRIGGER});
      issue(OP_CSR, 32'h0, SEL_DBG_CTRL, 1'b1, 32'h0);
      issue(OP_DRET);
      $display("test ebreak_trigger done");
      wb(1'b1, ADR_TRAP_BASE, TBASE);
      wb(1'b1, ADR_IRQ_CTRL, 32'h0000_0001);
      issue(OP_EBREAK, 32'h0000_0200);
      chk("ebreak_trap", {dm, rd.target}, {1'b0, TBASE});
      wb(1'b0, ADR_TRAP_CAUSE, 32'h0);
      chk("trap_cause", q, EXC_BREAKPOINT);
      wb(1'b0, ADR_TRAP_PC, 32'h0);
      chk("trap_pc", q, 32'h0000_0200);
      wb(1'b0, ADR_IRQ_CTRL, 32'h0);
      chk("gie_cleared", q[IRQ_CTRL_GIE], 1'b0);
      issue(OP_CSR, 32'h0000_0300, SEL_DBG_PC);
      chk("illegal_trap", {dm, rd.target}, {1'b0, TBASE});
      wb(1'b0, ADR_TRAP_CAUSE, 32'h0);
      chk("illegal_cause", q, EXC_ILLEGAL);
      $display("test traps done");
      issue(OP_PLAIN, 32'h0000_0500, SEL_DBG_CTRL, 1'b0, 32'h0, 1'b1);
      chk("req_squash", {sq, hs}, 2'b11);
      wb(1'b1, ADR_DBG_PC, 32'h0);
      wb(1'b0, ADR_DBG_PC, 32'h0);
      chk("req_pc", q, 32'h0000_0500);
      wb(1'b0, 8'h1C, 32'h0);
      chk("no_trap_value", q, 32'h0);
      $display("test run_request done");
      wb(1'b1, ADR_IRQ_MASK, 32'h0000_0001);
      wb(1'b1, ADR_IRQ_CTRL, 32'h0000_0001);
      @(posedge clk_i);
      irq <= 1'b1;
      repeat (4) @(posedge clk_i);
      #1;
      chk("irq_in_debug", {dm, sq, rd.valid}, 3'b100);
      issue(OP_DRET);
      chk("irq_dret", rd.target, 32'h0000_0500);
      @(posedge clk_i);
      irq <= 1'b0;
      #1;
      chk("irq_trap", {dm, rd.target}, {1'b0, TBASE});
      wb(1'b0, ADR_TRAP_CAUSE, 32'h0);
      chk("irq_cause", q, 32'h8000_0000);
      wb(1'b0, ADR_IRQ_CTRL, 32'h0);
      chk("irq_gie_cleared", q[IRQ_CTRL_GIE], 1'b0);
      $display("test interrupts done");
      finish_test;
   end
endmodule
